// ===== srtc_pkg.sv
// Constants, types and functions of the seconds-counter single-wire slave
package srtc_pkg;

	// Clock rate and bus timing, times in microseconds
	localparam int CLK_FREQ_MHZ          = 20;
	localparam int RESET_LOW_TIME_US     = 480;
	localparam int PRESENCE_WAIT_TIME_US = 20;
	localparam int PRESENCE_LOW_TIME_US  = 120;
	localparam int SAMPLE_TIME_US        = 30;
	localparam int READ_HOLD_TIME_US     = 30;

	localparam logic [15:0] RESET_LOW_CYCLES     = 16'(RESET_LOW_TIME_US * CLK_FREQ_MHZ);
	localparam logic [15:0] PRESENCE_WAIT_CYCLES = 16'(PRESENCE_WAIT_TIME_US * CLK_FREQ_MHZ);
	localparam logic [15:0] PRESENCE_LOW_CYCLES  = 16'(PRESENCE_LOW_TIME_US * CLK_FREQ_MHZ);
	localparam logic [15:0] SAMPLE_CYCLES        = 16'(SAMPLE_TIME_US * CLK_FREQ_MHZ);
	localparam logic [15:0] READ_HOLD_CYCLES     = 16'(READ_HOLD_TIME_US * CLK_FREQ_MHZ);

	// Crystal time base
	localparam int          OSC_FREQ_HZ  = 32768;
	localparam logic [14:0] OSC_DIV_LAST = 15'(OSC_FREQ_HZ - 1);

	// Command codes
	localparam logic [7:0] CMD_READ_ROM    = 8'h33;
	localparam logic [7:0] CMD_MATCH_ROM   = 8'h55;
	localparam logic [7:0] CMD_SEARCH_ROM  = 8'hF0;
	localparam logic [7:0] CMD_SKIP_ROM    = 8'hCC;
	localparam logic [7:0] CMD_READ_CLOCK  = 8'h66;
	localparam logic [7:0] CMD_WRITE_CLOCK = 8'h99;

	// Control byte layout
	localparam int CTRL_USER_LSB = 4;
	localparam int CTRL_OSC_HI   = 3;

	// Frame layout and counts
	localparam logic [2:0] BYTE_LAST       = 3'h7;
	localparam logic [5:0] ROM_LAST        = 6'h3F;
	localparam logic [2:0] CLOCK_FEED_LAST = 3'h4;
	localparam logic [1:0] TIME_BYTE_LAST  = 2'h3;
	localparam logic [1:0] SEARCH_WRITE    = 2'h2;
	localparam int         FIFO_WIDTH      = 8;
	localparam int         FIFO_DEPTH      = 16;

	// Values after reset
	localparam logic        OSC_EN_RST  = 1'b0;
	localparam logic [3:0]  USER_RST    = 4'h0;
	localparam logic [31:0] SECONDS_RST = 32'h0000_0000;

	// Identity, arbitrary values
	localparam logic [7:0]  FAMILY_CODE_DEF   = 8'h5A;
	localparam logic [47:0] SERIAL_NUMBER_DEF = 48'h0123_4567_89AB;

	// x^8 + x^5 + x^4 + 1, shifted right
	localparam logic [7:0] CRC_POLY_REFL = 8'h8C;

	typedef enum logic [2:0] {
		LK_IDLE   = 3'b000,
		LK_SLOT   = 3'b001,
		LK_RSTLOW = 3'b011,
		LK_PWAIT  = 3'b010,
		LK_PLOW   = 3'b110,
		LK_PREC   = 3'b111
	} srtc_link_t;

	typedef enum logic [3:0] {
		PR_ROMCMD  = 4'b0000,
		PR_ROMREAD = 4'b0001,
		PR_MATCH   = 4'b0011,
		PR_SEARCH  = 4'b0010,
		PR_FUNCCMD = 4'b0110,
		PR_READCLK = 4'b0111,
		PR_WRCTRL  = 4'b0101,
		PR_WRTIME  = 4'b0100,
		PR_WAITRST = 4'b1100
	} srtc_proto_t;

	function automatic logic [7:0] srtc_crc8(input logic [55:0] data);
		logic [7:0] crc;
		logic       fb;
		crc = 8'h00;
		for (int i = 0; i < 56; i++)
		begin
			fb  = crc[0] ^ data[i];
			crc = {1'b0, crc[7:1]} ^ (fb ? CRC_POLY_REFL : 8'h00);
		end
		return crc;
	endfunction

endpackage

// ===== srtc_top.sv
// Seconds-counter single-wire slave: bus engine, transmit FIFO and counter
// Contract
// - Hold 64-bit code: family, serial, check
// - Check value from x8+x5+x4+1 shift register
// - All bytes move least significant bit first
// - Clock commands only after a ROM command
// - Counter ticks from enabled 32.768 kHz base
// - Master accesses a buffer, not live counter
// - Control byte: user, two enables, zeros
// - Enable bits read back the running state
// - On write, bit 3 sets the enable
// - User bits stored, no other effect
// - 32-bit seconds counter that wraps around
// - Control byte first, then counter bytes ascending
// - Read command snapshots counter into buffer
// - Read repeats control plus four counter bytes
// - Reset pulse abandons a transfer cleanly
// - Written control byte takes effect at once
// - Buffer loads counter at next reset
// - Stopped counter holds value as storage
// - Slave only; master's falling edge starts slots
// - ROM commands 33h, 55h, F0h, CCh
// - Reset pulse, wait, then presence pulse
// - Slots timed from fall; sample or drive
`timescale 1ns/1ps

module srtc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic             flush,
	// Fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int          AW         = $clog2(DEPTH);
	localparam logic [AW:0] FULL_COUNT = (AW + 1)'(DEPTH);
	localparam logic [AW:0] PTR_STEP   = (AW + 1)'(1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_ptr_reg;
	logic [AW:0]      rd_ptr_reg;
	wire              do_push;
	wire              do_pop;

	assign in_ready  = (wr_ptr_reg - rd_ptr_reg) != FULL_COUNT;
	assign out_valid = wr_ptr_reg != rd_ptr_reg;
	assign out_data  = mem[rd_ptr_reg[AW-1:0]];
	assign do_push   = in_valid & in_ready;
	assign do_pop    = out_valid & out_ready;

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end
		else if (flush)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end
		else
		begin
			if (do_push)
				wr_ptr_reg <= wr_ptr_reg + PTR_STEP;
			if (do_pop)
				rd_ptr_reg <= rd_ptr_reg + PTR_STEP;
		end
	end

	always_ff @(posedge clk)
	begin
		if (do_push)
			mem[wr_ptr_reg[AW-1:0]] <= in_data;
	end
endmodule

module srtc_top #(
	parameter logic [7:0]  FAMILY_CODE      = srtc_pkg::FAMILY_CODE_DEF,
	parameter logic [47:0] SERIAL_NUMBER    = srtc_pkg::SERIAL_NUMBER_DEF,
	parameter logic [15:0] RESET_LOW_CYCLES = srtc_pkg::RESET_LOW_CYCLES
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic reset,
	// Single-wire data line, open drain
	input  wire logic dq_in,
	output logic      dq_out,
	output logic      dq_oe_n,
	// Crystal time base
	input  wire logic osc_in
);
	import srtc_pkg::*;

	localparam logic [7:0]  ROM_CRC  = srtc_crc8({SERIAL_NUMBER, FAMILY_CODE});
	localparam logic [63:0] ROM_CODE = {ROM_CRC, SERIAL_NUMBER, FAMILY_CODE};

	// Synchronisers and edge history
	logic dq_meta_reg;
	logic dq_sync_reg;
	logic dq_prev_reg;
	logic osc_meta_reg;
	logic osc_sync_reg;
	logic osc_prev_reg;

	// Bit-slot engine
	srtc_link_t  link_state_reg;
	srtc_link_t  link_next;
	logic [15:0] timer_reg;
	logic [15:0] timer_next;
	logic [15:0] low_cnt_reg;
	logic        oe_n_next;

	// Protocol engine and storage
	srtc_proto_t proto_reg;
	srtc_proto_t proto_next;
	logic [2:0]  bitcnt_reg;
	logic [7:0]  shift_reg;
	logic [5:0]  rom_idx_reg;
	logic [1:0]  step_reg;
	logic [2:0]  byte_idx_reg;
	logic        osc_en_reg;
	logic [3:0]  user_reg;
	logic [31:0] buffer_reg;
	logic [31:0] seconds_reg;
	logic        pending_reg;
	logic [14:0] prescale_reg;

	// Transmit FIFO
	wire       fifo_in_valid;
	wire       fifo_in_ready;
	wire [7:0] fifo_in_data;
	wire       fifo_out_valid;
	wire       fifo_out_ready;
	wire [7:0] fifo_out_data;

	// Decoded events
	wire       dq_fall;
	wire       osc_rise;
	wire       rst_evt;
	wire       bit_evt;
	wire       bit_val;
	wire [7:0] rx_byte;
	wire       byte_state;
	wire       byte_done;
	wire       rom_bit;
	wire       rom_last;
	wire       rom_check;
	wire       rom_bit_done;
	wire       rom_mismatch;
	wire       search_step;
	wire       cmd_read;
	wire       ctrl_done;
	wire       time_done;
	wire       time_last;
	wire       seconds_tick;
	wire       tx_active;
	wire       tx_bit;
	wire       drive_zero;
	wire [7:0] ctrl_byte;
	wire [7:0] feed_byte;
	wire       feed_push;

	assign dq_fall  = dq_prev_reg & ~dq_sync_reg;
	assign osc_rise = ~osc_prev_reg & osc_sync_reg;

	// long low counted from the master's fall
	assign rst_evt = ~dq_sync_reg & (low_cnt_reg == RESET_LOW_CYCLES - 16'h0001);

	assign bit_evt = (link_state_reg == LK_SLOT) & (timer_reg == SAMPLE_CYCLES);
	assign bit_val = dq_sync_reg;

	// shift in from the top, lowest bit first
	assign rx_byte    = {bit_val, shift_reg[7:1]};
	assign byte_state = (proto_reg == PR_ROMCMD) | (proto_reg == PR_FUNCCMD)
	                  | (proto_reg == PR_WRCTRL) | (proto_reg == PR_WRTIME)
	                  | (proto_reg == PR_READCLK);
	assign byte_done  = bit_evt & byte_state & (bitcnt_reg == BYTE_LAST);

	assign rom_bit      = ROM_CODE[rom_idx_reg];
	assign rom_last     = rom_idx_reg == ROM_LAST;
	assign search_step  = proto_reg == PR_SEARCH;
	assign rom_check    = (proto_reg == PR_MATCH) | (search_step & (step_reg == SEARCH_WRITE));
	assign rom_bit_done = bit_evt & ((proto_reg == PR_ROMREAD) | rom_check);
	assign rom_mismatch = bit_evt & rom_check & (bit_val != rom_bit);

	// clock commands decoded only in this state
	assign cmd_read  = byte_done & (proto_reg == PR_FUNCCMD) & (rx_byte == CMD_READ_CLOCK);
	assign ctrl_done = byte_done & (proto_reg == PR_WRCTRL);
	assign time_done = byte_done & (proto_reg == PR_WRTIME);
	assign time_last = time_done & (byte_idx_reg[1:0] == TIME_BYTE_LAST);

	// one second per 32768 enabled crystal edges
	assign seconds_tick = osc_en_reg & osc_rise & (prescale_reg == OSC_DIV_LAST);

	// user bits, enable twice, low bits zero
	// enable bits report the running state
	assign ctrl_byte = {user_reg, osc_en_reg, osc_en_reg, 2'b00};

	// control byte, then buffer bytes ascending
	assign feed_byte = (byte_idx_reg == 3'h0) ? ctrl_byte
	                 : buffer_reg[{byte_idx_reg[1:0] - 2'h1, 3'b000} +: 8];
	assign feed_push = (proto_reg == PR_READCLK) & fifo_in_ready;

	assign fifo_in_valid  = proto_reg == PR_READCLK;
	assign fifo_in_data   = feed_byte;
	assign fifo_out_ready = bit_evt & (proto_reg == PR_READCLK) & (bitcnt_reg == BYTE_LAST);

	assign tx_active = (proto_reg == PR_ROMREAD)
	                 | (search_step & (step_reg != SEARCH_WRITE))
	                 | ((proto_reg == PR_READCLK) & fifo_out_valid);
	assign tx_bit    = (proto_reg == PR_READCLK) ? fifo_out_data[bitcnt_reg]
	                 : (search_step & (step_reg != 2'h0)) ? ~rom_bit : rom_bit;
	// a one leaves the line alone
	assign drive_zero = tx_active & ~tx_bit;

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			dq_meta_reg  <= 1'b1;
			dq_sync_reg  <= 1'b1;
			dq_prev_reg  <= 1'b1;
			osc_meta_reg <= 1'b0;
			osc_sync_reg <= 1'b0;
			osc_prev_reg <= 1'b0;
		end
		else
		begin
			dq_meta_reg  <= dq_in;
			dq_sync_reg  <= dq_meta_reg;
			dq_prev_reg  <= dq_sync_reg;
			osc_meta_reg <= osc_in;
			osc_sync_reg <= osc_meta_reg;
			osc_prev_reg <= osc_sync_reg;
		end
	end

	// slots begin only at the master's fall
	always_comb
	begin
		link_next  = link_state_reg;
		timer_next = timer_reg + 16'h0001;
		oe_n_next  = dq_oe_n;
		if (rst_evt)
		begin
			link_next = LK_RSTLOW;
			oe_n_next = 1'b1;
		end
		else
		begin
			unique case (link_state_reg)
				LK_IDLE:
				begin
					timer_next = 16'h0000;
					if (dq_fall)
					begin
						link_next = LK_SLOT;
						oe_n_next = ~drive_zero;
					end
				end
				LK_SLOT:
				begin
					if (timer_reg == READ_HOLD_CYCLES)
						oe_n_next = 1'b1;
					if ((timer_reg > READ_HOLD_CYCLES) && dq_sync_reg)
						link_next = LK_IDLE;
				end
				LK_RSTLOW:
				begin
					timer_next = 16'h0000;
					if (dq_sync_reg)
						link_next = LK_PWAIT;
				end
				LK_PWAIT:
				begin
					if (timer_reg == PRESENCE_WAIT_CYCLES)
					begin
						link_next  = LK_PLOW;
						timer_next = 16'h0000;
						oe_n_next  = 1'b0;
					end
				end
				LK_PLOW:
				begin
					if (timer_reg == PRESENCE_LOW_CYCLES)
					begin
						link_next = LK_PREC;
						oe_n_next = 1'b1;
					end
				end
				LK_PREC:
				begin
					if (dq_sync_reg)
						link_next = LK_IDLE;
				end
				default:
				begin
					link_next = LK_IDLE;
					oe_n_next = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			link_state_reg <= LK_IDLE;
			timer_reg      <= 16'h0000;
			dq_oe_n        <= 1'b1;
			dq_out         <= 1'b0;
		end
		else
		begin
			link_state_reg <= link_next;
			timer_reg      <= timer_next;
			dq_oe_n        <= oe_n_next;
			dq_out         <= 1'b0;
		end
	end

	// a read-zero hold inside a reset still counts
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			low_cnt_reg <= 16'h0000;
		else if (dq_sync_reg | (link_state_reg == LK_PLOW) | (link_state_reg == LK_PREC))
			low_cnt_reg <= 16'h0000;
		else if (low_cnt_reg != RESET_LOW_CYCLES)
			low_cnt_reg <= low_cnt_reg + 16'h0001;
	end

	// a reset pulse returns to the ROM stage
	always_comb
	begin
		proto_next = proto_reg;
		if (rst_evt)
			proto_next = PR_ROMCMD;
		else
		begin
			unique case (proto_reg)
				PR_ROMCMD:
				begin
					if (byte_done)
					begin
						if (rx_byte == CMD_READ_ROM)
							proto_next = PR_ROMREAD;
						else if (rx_byte == CMD_MATCH_ROM)
							proto_next = PR_MATCH;
						else if (rx_byte == CMD_SEARCH_ROM)
							proto_next = PR_SEARCH;
						else if (rx_byte == CMD_SKIP_ROM)
							proto_next = PR_FUNCCMD;
						else
							proto_next = PR_WAITRST;
					end
				end
				PR_ROMREAD, PR_MATCH, PR_SEARCH:
				begin
					if (rom_mismatch)
						proto_next = PR_WAITRST;
					else if (rom_bit_done & rom_last)
						proto_next = PR_FUNCCMD;
				end
				PR_FUNCCMD:
				begin
					if (byte_done)
					begin
						if (rx_byte == CMD_READ_CLOCK)
							proto_next = PR_READCLK;
						else if (rx_byte == CMD_WRITE_CLOCK)
							proto_next = PR_WRCTRL;
						else
							proto_next = PR_WAITRST;
					end
				end
				PR_WRCTRL:
				begin
					if (byte_done)
						proto_next = PR_WRTIME;
				end
				PR_WRTIME:
				begin
					if (time_last)
						proto_next = PR_WAITRST;
				end
				PR_READCLK, PR_WAITRST:
					proto_next = proto_reg;
				default:
					proto_next = PR_WAITRST;
			endcase
		end
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			proto_reg  <= PR_WAITRST;
			bitcnt_reg <= 3'h0;
			shift_reg  <= 8'h00;
		end
		else
		begin
			proto_reg <= proto_next;
			if (rst_evt)
				bitcnt_reg <= 3'h0;
			else if (bit_evt & byte_state)
				bitcnt_reg <= bitcnt_reg + 3'h1;
			if (bit_evt)
				shift_reg <= rx_byte;
		end
	end

	// walk the code from family code LSB
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			rom_idx_reg <= 6'h00;
			step_reg    <= 2'h0;
		end
		else if (rst_evt)
		begin
			rom_idx_reg <= 6'h00;
			step_reg    <= 2'h0;
		end
		else
		begin
			if (rom_bit_done)
				rom_idx_reg <= rom_idx_reg + 6'h01;
			if (bit_evt & search_step)
				step_reg <= (step_reg == SEARCH_WRITE) ? 2'h0 : step_reg + 2'h1;
		end
	end

	// feed the five-byte frame over and over
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			byte_idx_reg <= 3'h0;
		else if (rst_evt | cmd_read | ctrl_done)
			byte_idx_reg <= 3'h0;
		else if (feed_push)
			byte_idx_reg <= (byte_idx_reg == CLOCK_FEED_LAST) ? 3'h0 : byte_idx_reg + 3'h1;
		else if (time_done)
			byte_idx_reg <= byte_idx_reg + 3'h1;
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			osc_en_reg <= OSC_EN_RST;
			user_reg   <= USER_RST;
		end
		else if (ctrl_done)
		begin
			osc_en_reg <= rx_byte[CTRL_OSC_HI];
			user_reg   <= rx_byte[CTRL_USER_LSB +: 4];
		end
	end

	// buffer between master and live counter
	// snapshot on the last command bit
	// write bytes land in the buffer
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			buffer_reg  <= SECONDS_RST;
			pending_reg <= 1'b0;
		end
		else
		begin
			if (cmd_read)
				buffer_reg <= seconds_reg;
			else if (time_done)
				buffer_reg[{byte_idx_reg[1:0], 3'b000} +: 8] <= rx_byte;
			if (rst_evt)
				pending_reg <= 1'b0;
			else if (time_last)
				pending_reg <= 1'b1;
		end
	end

	// buffer reaches the counter at reset
	// no tick while the crystal is stopped
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			seconds_reg <= SECONDS_RST;
		else if (rst_evt & pending_reg)
			seconds_reg <= buffer_reg;
		else if (seconds_tick)
			seconds_reg <= seconds_reg + 32'h0000_0001;
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			prescale_reg <= 15'h0000;
		else if (osc_en_reg & osc_rise)
			prescale_reg <= (prescale_reg == OSC_DIV_LAST) ? 15'h0000 : prescale_reg + 15'h0001;
	end

	// leftover read bytes dropped at reset
	srtc_fifo #(
		.WIDTH (FIFO_WIDTH),
		.DEPTH (FIFO_DEPTH)
	) u_tx_fifo (
		.clk       (clk),
		.reset     (reset),
		.flush     (rst_evt),
		.in_valid  (fifo_in_valid),
		.in_ready  (fifo_in_ready),
		.in_data   (fifo_in_data),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_out_ready),
		.out_data  (fifo_out_data)
	);
endmodule

// ===== srtc_props.sv
// Pin-level concurrent checks of the single-wire seconds slave
`timescale 1ns/1ps

module srtc_props #(
	parameter logic [15:0] RESET_LOW_CYCLES = 16'h2580
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Data line
	input wire logic dq_in,
	input wire logic dq_out,
	input wire logic dq_oe_n,
	// Time base
	input wire logic osc_in
);
	logic [15:0] mlow_reg;
	logic [15:0] high_reg;
	logic [15:0] olow_reg;
	logic        long_reg;
	logic        pres_reg;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	// Low run from a master fall, line high run, device pull run, bus reset seen
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			mlow_reg <= 16'h0000;
			high_reg <= 16'h0000;
			olow_reg <= 16'h0000;
			long_reg <= 1'b0;
			pres_reg <= 1'b0;
		end
		else
		begin
			mlow_reg <= dq_in ? 16'h0000
				: (!(!dq_oe_n && pres_reg) && mlow_reg != 16'hFFFF) ? mlow_reg + 16'h0001
				: mlow_reg;
			high_reg <= !dq_in ? 16'h0000 : (high_reg != 16'hFFFF) ? high_reg + 16'h0001 : high_reg;
			olow_reg <= dq_oe_n ? 16'h0000 : olow_reg + 16'h0001;
			long_reg <= (mlow_reg >= RESET_LOW_CYCLES) ? 1'b1 : dq_oe_n & long_reg;
			pres_reg <= dq_oe_n ? long_reg : pres_reg;
		end
	end

	sequence s_reset_end;
		$rose(dq_in) && long_reg;
	endsequence

	sequence s_pull_start;
		$fell(dq_oe_n) && !pres_reg;
	endsequence

	AST_OPEN_DRAIN: assert property (dq_out == 1'b0)
		else $error("data output not held at zero");
	AST_QUIET_AFTER_RESET: assert property ($fell(reset) |-> dq_oe_n [*8])
		else $error("line pulled right after reset");
	AST_PRES_WAIT: assert property (long_reg && dq_in && high_reg < 16'h012C |-> dq_oe_n)
		else $error("presence started too early");
	AST_PRES_COMES: assert property (s_reset_end |-> ##[300:1000] !dq_oe_n)
		else $error("no presence pulse after bus reset");
	AST_PRES_DELAY: assert property ($fell(dq_oe_n) && pres_reg |-> high_reg <= 16'h04B0)
		else $error("presence started too late");
	AST_PRES_LEN: assert property ($rose(dq_oe_n) && pres_reg
		|-> olow_reg >= 16'h04B0 && olow_reg <= 16'h12C0)
		else $error("presence pulse length out of range");
	AST_READ_START: assert property (s_pull_start
		|-> !$past(dq_in) && mlow_reg >= 16'h0001 && mlow_reg <= 16'h0008)
		else $error("data pull not inside a master slot");
	AST_READ_HOLD: assert property ($rose(dq_oe_n) && !pres_reg
		|-> olow_reg >= 16'h021C && olow_reg <= 16'h0280)
		else $error("read zero hold length wrong");
endmodule

bind srtc_top srtc_props #(.RESET_LOW_CYCLES(RESET_LOW_CYCLES)) u_srtc_props (
	.clk(clk), .reset(reset), .dq_in(dq_in),
	.dq_out(dq_out), .dq_oe_n(dq_oe_n), .osc_in(osc_in)
);

// ===== srtc_master.sv
// Behavioural single-wire bus master
`timescale 1ns/1ps

module srtc_master (
	// Clock
	input  wire logic clk,
	// Resolved line and master pull-down
	input  wire logic dq_line,
	output logic      master_low
);
	initial master_low = 1'b0;

	// Change the pull just after an edge, hold it n edges
	task automatic drive(input logic low, input int n);
		@(posedge clk);
		#1;
		master_low = low;
		repeat (n - 1) @(posedge clk);
	endtask

	// long low pulse, then watch for presence
	task automatic bus_reset(output logic seen);
		seen = 1'b0;
		drive(1'b1, 850);
		drive(1'b0, 1);
		for (int i = 0; i < 1500; i++)
		begin
			@(posedge clk);
			#2;
			if (dq_line === 1'b0)
				seen = 1'b1;
		end
		drive(1'b0, 1600);
	endtask

	// slot opens with a fall, least bit first
	task automatic write_byte(input logic [7:0] b);
		for (int i = 0; i < 8; i++)
		begin
			drive(1'b1, b[i] ? 20 : 615);
			drive(1'b0, b[i] ? 605 : 10);
		end
	endtask

	task automatic read_byte(output logic [7:0] b);
		for (int i = 0; i < 8; i++)
		begin
			drive(1'b1, 20);
			drive(1'b0, 280);
			#2;
			b[i] = dq_line;
			drive(1'b0, 325);
		end
	endtask
endmodule

// ===== srtc_top_test.sv
// Self-checking bench of the single-wire seconds slave
`timescale 1ns/1ps

module srtc_top_test;
	import srtc_pkg::*;

	// Identity values are arbitrary
	localparam logic [7:0]  FAM = 8'h3C;
	localparam logic [47:0] SER = 48'hA1B2_C3D4_E5F6;

	logic clk;
	logic reset;
	logic osc_in;
	logic dq_line;
	logic dq_out;
	logic dq_oe_n;
	logic master_low;
	int   errors;
	int   samples_checked;

	// Pull-up wire: low when either party pulls
	assign dq_line = (dq_oe_n === 1'b0 || master_low) ? 1'b0 : 1'b1;

	srtc_top #(.FAMILY_CODE(FAM), .SERIAL_NUMBER(SER), .RESET_LOW_CYCLES(16'h0320)) u_srtc_top (
		.clk(clk), .reset(reset), .dq_in(dq_line),
		.dq_out(dq_out), .dq_oe_n(dq_oe_n), .osc_in(osc_in)
	);

	srtc_master u_srtc_master (.clk(clk), .dq_line(dq_line), .master_low(master_low));

	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// Crystal runs throughout; counter must ignore it while disabled
	always @(posedge clk) osc_in <= #1 ~osc_in;

	function automatic logic [7:0] crc_bits(input logic [63:0] d, input int n);
		logic [7:0] c;
		logic       f;
		c = 8'h00;
		for (int i = 0; i < n; i++)
		begin
			f = c[0] ^ d[i];
			c = c >> 1;
			if (f)
				c = c ^ 8'h8C;
		end
		return c;
	endfunction

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict;
		$display("checks=%0d errors=%0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial
	begin
		logic        p;
		logic [7:0]  b;
		logic [63:0] rom;
		errors = 0;
		samples_checked = 0;
		reset = 1'b1;
		osc_in = 1'b0;
		repeat (6) @(posedge clk);
		#1;
		reset = 1'b0;
		repeat (4) @(posedge clk);
		// Write control with enable bits disagreeing, then four time bytes
		u_srtc_master.bus_reset(p);
		check(64'(p), 64'h1); // presence seen
		u_srtc_master.write_byte(CMD_SKIP_ROM); // addressing first
		u_srtc_master.write_byte(CMD_WRITE_CLOCK); // write clock
		u_srtc_master.write_byte(8'hA4); // bit 3 clear wins
		for (int i = 0; i < 4; i++)
			u_srtc_master.write_byte(8'h12 + 8'(i) * 8'h22); // time bytes
		// Next bus reset loads the counter; read identity then time
		u_srtc_master.bus_reset(p);
		check(64'(p), 64'h1); // presence seen
		u_srtc_master.write_byte(CMD_READ_ROM); // identity read
		for (int i = 0; i < 8; i++)
		begin
			u_srtc_master.read_byte(b);
			rom[8*i +: 8] = b;
		end
		check(rom, {crc_bits({SER, FAM}, 56), SER, FAM}); // code layout
		check(64'(crc_bits(rom, 64)), 64'h0); // residue zero
		u_srtc_master.write_byte(CMD_READ_CLOCK); // snapshot
		u_srtc_master.read_byte(b);
		check(64'(b), 64'hA0); // control layout
		for (int i = 0; i < 4; i++)
		begin
			u_srtc_master.read_byte(b);
			check(64'(b), 64'(8'h12 + 8'(i) * 8'h22)); // held time order
		end
		u_srtc_master.read_byte(b);
		check(64'(b), 64'hA0); // sequence repeats
		// Bus reset while the device would pull the next read bit low
		u_srtc_master.bus_reset(p);
		check(64'(p), 64'h1); // read abandoned, presence given
		give_verdict();
	end
endmodule
